// *** design/tmc_pkg.sv ***
`default_nettype none

package tmc_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAR = 8'h04;
    localparam logic [7:0] OFS_POS = 8'h08;
    localparam logic [7:0] OFS_HMARG = 8'h0C;
    localparam logic [7:0] OFS_VMARG = 8'h10;

    // control register fields and reset values
    localparam int CTRL_LOCAL_BIT = 0;
    localparam int CTRL_AUTOLF_BIT = 1;
    localparam logic CTRL_LOCAL_RST = 1'h1;
    localparam logic CTRL_AUTOLF_RST = 1'h0;

    // status field positions
    localparam int POS_CARR_LSB = 0;
    localparam int POS_LINE_LSB = 8;
    localparam int POS_PAGE_LSB = 16;
    localparam int HM_LEFT_LSB = 0;
    localparam int HM_RIGHT_LSB = 8;
    localparam int VM_TOP_LSB = 0;
    localparam int VM_LOWER_LSB = 8;

    // carriage and paper limits
    localparam logic [7:0] POS_MIN = 8'h01;
    localparam logic [7:0] POS_MAX = 8'h84;
    localparam logic [6:0] LINE_FIRST = 7'h01;
    localparam logic [6:0] PAGE_DEFAULT = 7'h42;
    localparam logic [6:0] PAGE_MIN = 7'h02;
    localparam logic [6:0] PAGE_MAX = 7'h7E;

    // character codes
    localparam logic [7:0] CH_BS = 8'h08;
    localparam logic [7:0] CH_HT = 8'h09;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_FF = 8'h0C;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_ESC = 8'h1B;
    localparam logic [7:0] CH_PRINT_LO = 8'h20;
    localparam logic [7:0] CH_PRINT_HI = 8'h7E;
    localparam logic [7:0] CH_DIG0 = 8'h30;
    localparam logic [7:0] CH_DIG9 = 8'h39;
    localparam logic [7:0] CH_UC_C = 8'h43;
    localparam logic [7:0] CH_UC_L = 8'h4C;
    localparam logic [7:0] CH_UC_P = 8'h50;
    localparam logic [7:0] CH_UC_T = 8'h54;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ESC = 5'b00010,
        ST_ESC_CR = 5'b00100,
        ST_ESC_FF = 5'b01000,
        ST_ESC_HT = 5'b10000
    } tmc_state_t;

    typedef enum logic [3:0] {
        CMD_PRINT = 4'h0,
        CMD_CR = 4'h1,
        CMD_LF = 4'h2,
        CMD_BS = 4'h3,
        CMD_FF = 4'h4,
        CMD_SET_LEFT = 4'h5,
        CMD_SET_RIGHT = 4'h6,
        CMD_SET_TOP = 4'h7,
        CMD_SET_LOWER = 4'h8,
        CMD_CLR_VERT = 4'h9,
        CMD_PAGE_LEN = 4'hA,
        CMD_ABS_TAB = 4'hB,
        CMD_CLEAR = 4'hC
    } tmc_cmd_t;

endpackage : tmc_pkg

`default_nettype wire

// *** design/tmc_esc_parser.sv ***
`timescale 1ns/1ps
`default_nettype none

module tmc_esc_parser (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic charValid,
    input wire logic [7:0] charData,
    output logic cmdValid,
    output var tmc_pkg::tmc_cmd_t cmdCode,
    output logic [7:0] cmdArg
);

    tmc_pkg::tmc_state_t state_ff;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_ff <= tmc_pkg::ST_IDLE;
            cmdValid <= 1'b0;
            cmdCode <= tmc_pkg::CMD_PRINT;
            cmdArg <= 8'h00;
        end
        else
        begin
            cmdValid <= 1'b0;
            if (charValid)
            begin
                cmdArg <= charData;
                state_ff <= tmc_pkg::ST_IDLE;
                case (state_ff)
                    tmc_pkg::ST_IDLE:
                    begin
                        cmdValid <= 1'b1;
                        case (charData)
                            tmc_pkg::CH_ESC:
                            begin
                                cmdValid <= 1'b0;
                                state_ff <= tmc_pkg::ST_ESC;
                            end
                            tmc_pkg::CH_CR: cmdCode <= tmc_pkg::CMD_CR;
                            tmc_pkg::CH_LF: cmdCode <= tmc_pkg::CMD_LF;
                            tmc_pkg::CH_BS: cmdCode <= tmc_pkg::CMD_BS;
                            tmc_pkg::CH_FF: cmdCode <= tmc_pkg::CMD_FF;
                            default:
                            begin
                                cmdCode <= tmc_pkg::CMD_PRINT;
                                // other control codes are outside this block
                                cmdValid <= (charData >= tmc_pkg::CH_PRINT_LO)
                                    && (charData <= tmc_pkg::CH_PRINT_HI);
                            end
                        endcase
                    end
                    tmc_pkg::ST_ESC:
                    begin
                        cmdValid <= 1'b1;
                        case (charData)
                            tmc_pkg::CH_DIG9: cmdCode <= tmc_pkg::CMD_SET_LEFT;
                            tmc_pkg::CH_DIG0: cmdCode <= tmc_pkg::CMD_SET_RIGHT;
                            tmc_pkg::CH_UC_T: cmdCode <= tmc_pkg::CMD_SET_TOP;
                            tmc_pkg::CH_UC_L: cmdCode <= tmc_pkg::CMD_SET_LOWER;
                            tmc_pkg::CH_UC_C: cmdCode <= tmc_pkg::CMD_CLR_VERT;
                            tmc_pkg::CH_CR:
                            begin
                                cmdValid <= 1'b0;
                                state_ff <= tmc_pkg::ST_ESC_CR;
                            end
                            tmc_pkg::CH_FF:
                            begin
                                cmdValid <= 1'b0;
                                state_ff <= tmc_pkg::ST_ESC_FF;
                            end
                            tmc_pkg::CH_HT:
                            begin
                                cmdValid <= 1'b0;
                                state_ff <= tmc_pkg::ST_ESC_HT;
                            end
                            default: cmdValid <= 1'b0;
                        endcase
                    end
                    tmc_pkg::ST_ESC_CR:
                    begin
                        // [RL2] clear on the final byte
                        // issued as soon as the final P byte is written; there is no buffer
                        cmdValid <= (charData == tmc_pkg::CH_UC_P);
                        cmdCode <= tmc_pkg::CMD_CLEAR;
                    end
                    tmc_pkg::ST_ESC_FF:
                    begin
                        // [RL18] page length byte
                        cmdValid <= 1'b1;
                        cmdCode <= tmc_pkg::CMD_PAGE_LEN;
                    end
                    tmc_pkg::ST_ESC_HT:
                    begin
                        cmdValid <= 1'b1;
                        cmdCode <= tmc_pkg::CMD_ABS_TAB;
                    end
                    default: state_ff <= tmc_pkg::ST_IDLE;
                endcase
            end
        end
    end

endmodule : tmc_esc_parser

`default_nettype wire

// *** design/tmc_margin_ctrl.sv ***
// Summary of operation
// [RL1] power-on in local, or remote ESC CR P, clears and resets the mechanism
// [RL2] remote clear acts only when its sequence leaves the print buffer; here it acts when the P byte is written, with no buffer
// [RL3] after clear left margin is position 1, right margin position 132
// [RL4] after clear top margin is current line, lower margin 66 lines on
// [RL5] ESC 9 stores carriage as left margin, ESC 0 as right margin
// [RL6] carriage return goes to the programmed left margin
// [RL7] backspace may pass left margin but never below position 1
// [RL8] crossing the right margin sounds the alarm, printing continues
// [RL9] at position 132 further printable characters are discarded
// [RL10] a new page length moves the lower margin to the new page end
// [RL11] vertical margins accepted only inside page with top before lower
// [RL12] ESC T stores the current line as top margin
// [RL13] ESC L stores the current line as lower margin
// [RL14] ESC C restores top to first line and lower to last line
// [RL15] form feed or line feed past lower margin goes to next top margin
// [RL16] absolute horizontal tab may go left of the margin down to 1
// [RL17] auto line feed switch adds a local line feed to each return
// [RL18] ESC FF n sets the page length to the value of n; the code ignores any n outside 2 to 126
// [RL19] carriage counter 1 to 132 and line counter from 1 track motion
`timescale 1ns/1ps
`default_nettype none

module tmc_margin_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic printStrobe,
    output logic [7:0] printChar,
    output logic alarmPulse,
    output logic discardPulse,
    output logic mechResetPulse,
    output logic [7:0] carriagePos,
    output logic [6:0] paperLine
);

    logic localMode_ff;
    logic autoLf_ff;
    logic [7:0] leftMargin_ff;
    logic [7:0] rightMargin_ff;
    logic [6:0] topMargin_ff;
    logic [6:0] lowerMargin_ff;
    logic [6:0] pageLen_ff;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic cmdValid;
    tmc_pkg::tmc_cmd_t cmdCode;
    logic [7:0] cmdArg;

    // one wait state keeps pready and prdata registered
    wire apbAccess = psel && penable;
    wire apbDone = apbAccess && pready;
    wire apbWrite = apbDone && pwrite && !pslverr;
    wire charValid = apbWrite && (paddr == tmc_pkg::OFS_CHAR);

    wire doCmd = cmdValid;
    // [RL1] remote clear gated by mode
    wire doClear = doCmd && (cmdCode == tmc_pkg::CMD_CLEAR) && !localMode_ff;
    wire doLineFeed = doCmd && ((cmdCode == tmc_pkg::CMD_LF)
        || ((cmdCode == tmc_pkg::CMD_CR) && autoLf_ff));
    wire atRightEnd = (carriagePos == tmc_pkg::POS_MAX);
    wire [6:0] argLine = cmdArg[6:0];

    function automatic logic [6:0] advanceLine(input logic [6:0] line,
        input logic [6:0] lower, input logic [6:0] top, input logic [6:0] len);
        begin
            // [RL15] lower margin wraps to top
            if (line == lower)
                advanceLine = top;
            else if (line >= len)
                advanceLine = tmc_pkg::LINE_FIRST;
            else
                advanceLine = line + 7'h01;
        end
    endfunction : advanceLine

    tmc_esc_parser u_parser (
        .sys_clk(sys_clk),
        .rst(rst),
        .charValid(charValid),
        .charData(pwdata[7:0]),
        .cmdValid(cmdValid),
        .cmdCode(cmdCode),
        .cmdArg(cmdArg)
    );

    always_comb
    begin
        nxt_prdata = 32'h00000000;
        nxt_pslverr = 1'b0;
        case (paddr)
            tmc_pkg::OFS_CTRL:
            begin
                nxt_prdata[tmc_pkg::CTRL_LOCAL_BIT] = localMode_ff;
                nxt_prdata[tmc_pkg::CTRL_AUTOLF_BIT] = autoLf_ff;
            end
            tmc_pkg::OFS_CHAR: nxt_prdata = 32'h00000000;
            tmc_pkg::OFS_POS:
            begin
                nxt_prdata[tmc_pkg::POS_CARR_LSB +: 8] = carriagePos;
                nxt_prdata[tmc_pkg::POS_LINE_LSB +: 7] = paperLine;
                nxt_prdata[tmc_pkg::POS_PAGE_LSB +: 7] = pageLen_ff;
            end
            tmc_pkg::OFS_HMARG:
            begin
                nxt_prdata[tmc_pkg::HM_LEFT_LSB +: 8] = leftMargin_ff;
                nxt_prdata[tmc_pkg::HM_RIGHT_LSB +: 8] = rightMargin_ff;
            end
            tmc_pkg::OFS_VMARG:
            begin
                nxt_prdata[tmc_pkg::VM_TOP_LSB +: 7] = topMargin_ff;
                nxt_prdata[tmc_pkg::VM_LOWER_LSB +: 7] = lowerMargin_ff;
            end
            default: nxt_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apbAccess && !pready;
            if (apbAccess && !pready)
            begin
                prdata <= pwrite ? 32'h00000000 : nxt_prdata;
                pslverr <= nxt_pslverr;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            localMode_ff <= tmc_pkg::CTRL_LOCAL_RST;
            autoLf_ff <= tmc_pkg::CTRL_AUTOLF_RST;
        end
        else if (apbWrite && (paddr == tmc_pkg::OFS_CTRL))
        begin
            localMode_ff <= pwdata[tmc_pkg::CTRL_LOCAL_BIT];
            autoLf_ff <= pwdata[tmc_pkg::CTRL_AUTOLF_BIT];
        end
    end

    // horizontal: carriage and left/right margins
    always_ff @(posedge sys_clk)
    begin
        if (rst || doClear)
        begin
            // [RL3] outermost horizontal margins
            carriagePos <= tmc_pkg::POS_MIN;
            leftMargin_ff <= tmc_pkg::POS_MIN;
            rightMargin_ff <= tmc_pkg::POS_MAX;
        end
        else if (doCmd)
        begin
            case (cmdCode)
                tmc_pkg::CMD_PRINT:
                begin
                    // [RL19] carriage advances per character
                    if (!atRightEnd)
                        carriagePos <= carriagePos + 8'h01;
                end
                // [RL6] return to left margin
                tmc_pkg::CMD_CR: carriagePos <= leftMargin_ff;
                tmc_pkg::CMD_BS:
                begin
                    // [RL7] floor at position 1
                    if (carriagePos > tmc_pkg::POS_MIN)
                        carriagePos <= carriagePos - 8'h01;
                end
                tmc_pkg::CMD_ABS_TAB:
                begin
                    // [RL16] tab ignores left margin
                    if ((cmdArg >= tmc_pkg::POS_MIN) && (cmdArg <= tmc_pkg::POS_MAX))
                        carriagePos <= cmdArg;
                end
                // [RL5] store horizontal margins
                tmc_pkg::CMD_SET_LEFT: leftMargin_ff <= carriagePos;
                tmc_pkg::CMD_SET_RIGHT: rightMargin_ff <= carriagePos;
                default: carriagePos <= carriagePos;
            endcase
        end
    end

    // vertical: paper line, page length and top/lower margins
    always_ff @(posedge sys_clk)
    begin
        if (rst || doClear)
        begin
            // [RL4] current paper line becomes line 1
            paperLine <= tmc_pkg::LINE_FIRST;
            topMargin_ff <= tmc_pkg::LINE_FIRST;
            lowerMargin_ff <= tmc_pkg::PAGE_DEFAULT;
            pageLen_ff <= tmc_pkg::PAGE_DEFAULT;
        end
        else if (doLineFeed)
        begin
            // [RL17] auto line feed on return
            paperLine <= advanceLine(paperLine, lowerMargin_ff, topMargin_ff, pageLen_ff);
        end
        else if (doCmd)
        begin
            case (cmdCode)
                // [RL15] form feed to next top
                tmc_pkg::CMD_FF: paperLine <= topMargin_ff;
                tmc_pkg::CMD_SET_TOP:
                begin
                    // [RL12] [RL11] top must precede lower
                    if (paperLine < lowerMargin_ff)
                        topMargin_ff <= paperLine;
                end
                tmc_pkg::CMD_SET_LOWER:
                begin
                    // [RL13] [RL11] lower inside page
                    if ((paperLine > topMargin_ff) && (paperLine <= pageLen_ff))
                        lowerMargin_ff <= paperLine;
                end
                tmc_pkg::CMD_CLR_VERT:
                begin
                    // [RL14] restore page limits
                    topMargin_ff <= tmc_pkg::LINE_FIRST;
                    lowerMargin_ff <= pageLen_ff;
                end
                tmc_pkg::CMD_PAGE_LEN:
                begin
                    // [RL18] [RL10] lower follows page end
                    if ((argLine >= tmc_pkg::PAGE_MIN) && (argLine <= tmc_pkg::PAGE_MAX)
                        && !cmdArg[7])
                    begin
                        pageLen_ff <= argLine;
                        lowerMargin_ff <= argLine;
                        if (topMargin_ff >= argLine)
                            topMargin_ff <= tmc_pkg::LINE_FIRST;
                        if (paperLine > argLine)
                            paperLine <= tmc_pkg::LINE_FIRST;
                    end
                end
                default: paperLine <= paperLine;
            endcase
        end
    end

    // event outputs toward the mechanism
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            printStrobe <= 1'b0;
            printChar <= 8'h00;
            alarmPulse <= 1'b0;
            discardPulse <= 1'b0;
            // held high throughout reset and dropped on the first clock edge after reset is released
            mechResetPulse <= 1'b1;
        end
        else
        begin
            mechResetPulse <= doClear;
            printStrobe <= 1'b0;
            alarmPulse <= 1'b0;
            discardPulse <= 1'b0;
            if (doCmd && (cmdCode == tmc_pkg::CMD_PRINT))
            begin
                printChar <= cmdArg;
                // [RL9] discard at the extreme right
                printStrobe <= !atRightEnd;
                discardPulse <= atRightEnd;
                // [RL8] alarm on passing right margin
                alarmPulse <= (carriagePos == rightMargin_ff) && !atRightEnd;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence sClearCmd;
        cmdValid && (cmdCode == tmc_pkg::CMD_CLEAR) && !localMode_ff;
    endsequence
    sequence sClearDone;
        mechResetPulse && (carriagePos == tmc_pkg::POS_MIN);
    endsequence

    a_clear_mech: assert property (sClearCmd |=> sClearDone) // [RL1]
        else $error("clear did not reset mechanism");
    a_clear_hmargins: assert property (sClearCmd |=> (leftMargin_ff == tmc_pkg::POS_MIN)
        && (rightMargin_ff == tmc_pkg::POS_MAX)) // [RL3]
        else $error("horizontal margins not outermost after clear");
    a_clear_vmargins: assert property (sClearCmd |=> (topMargin_ff == paperLine)
        && (lowerMargin_ff == tmc_pkg::PAGE_DEFAULT)) // [RL4]
        else $error("vertical margins wrong after clear");
    a_left_store: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_SET_LEFT) && !doClear
        |=> leftMargin_ff == $past(carriagePos)) // [RL5]
        else $error("left margin not taken from carriage");
    a_cr_left: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_CR)
        |=> carriagePos == $past(leftMargin_ff)) // [RL6]
        else $error("return did not reach left margin");
    a_bs_floor: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_BS)
        && (carriagePos == tmc_pkg::POS_MIN) |=> carriagePos == tmc_pkg::POS_MIN) // [RL7]
        else $error("backspace went below position 1");
    a_alarm_cross: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_PRINT)
        && (carriagePos == rightMargin_ff) && !atRightEnd
        |=> alarmPulse && printStrobe ##1 !alarmPulse) // [RL8]
        else $error("alarm missing at right margin");
    a_discard_end: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_PRINT) && atRightEnd
        |=> discardPulse && !printStrobe) // [RL9]
        else $error("character at extreme right not discarded");
    a_top_before: assert property (topMargin_ff < lowerMargin_ff) // [RL11]
        else $error("top margin not before lower margin");
    a_ff_top: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_FF)
        |=> paperLine == $past(topMargin_ff)) // [RL15]
        else $error("form feed missed top margin");
    a_lower_wrap: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_LF)
        && (paperLine == lowerMargin_ff) |=> paperLine == $past(topMargin_ff)) // [RL15]
        else $error("line feed past lower margin missed top");
    a_auto_line_feed_switch: assert property (cmdValid && (cmdCode == tmc_pkg::CMD_CR) && autoLf_ff
        && (paperLine != lowerMargin_ff) && (paperLine < pageLen_ff)
        |=> paperLine == $past(paperLine) + 7'h01) // [RL17]
        else $error("auto line feed did not advance paper");

endmodule : tmc_margin_ctrl

`default_nettype wire

// *** test/tmc_apb_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module tmc_apb_host (
    input wire logic sys_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    int tmo = 0;

    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // request held until the pready edge, then released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge sys_clk);
            if (pready === 1'b1)
                break;
        end
        if (i == 20)
            tmo++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : tmc_apb_host

`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) \
    begin \
        nChecks++; \
        if ((a) !== (b)) \
        begin \
            fails++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
        end \
    end

module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic rstQ = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, printStrobe, alarmPulse;
    logic discardPulse, mechResetPulse;
    logic [7:0] paddr, printChar, carriagePos;
    logic [6:0] paperLine;
    logic [31:0] pwdata, prdata;
    int fails = 0, nChecks = 0, n;
    // four-state tallies so an unknown pulse cannot pass as zero
    integer gS = 0, gA = 0, gD = 0, gM = 0;
    int pos = 1, ln = 1, lm = 1, rm = 132, tp = 1, lw = 66, pg = 66;
    int esc = 0, loc = 1, alf = 0, nS = 0, nA = 0, nD = 0, nM = 0, pc = 0;

    always #25 sys_clk = ~sys_clk;

    tmc_margin_ctrl uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .printStrobe, .printChar, .alarmPulse,
        .discardPulse, .mechResetPulse, .carriagePos, .paperLine);
    tmc_apb_host h (.sys_clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite,
        .paddr, .pwdata);

    // pulse tally, skipping the power-on clear marker
    always @(posedge sys_clk)
    begin
        rstQ <= rst;
        if (!rst && !rstQ)
        begin
            gS += printStrobe;
            gA += alarmPulse;
            gD += discardPulse;
            gM += mechResetPulse;
        end
    end

    function automatic void lf();
        if (ln == lw) ln = tp;
        else if (ln >= pg) ln = 1;
        else ln++;
    endfunction : lf

    function automatic void mdl(input int c);
        case (esc)
            1: begin
                esc = 0;
                case (c)
                    8'h39: lm = pos;
                    8'h30: rm = pos;
                    8'h54: if (ln < lw) tp = ln;
                    8'h4C: if (tp < ln && ln <= pg) lw = ln;
                    8'h43: begin tp = 1; lw = pg; end
                    8'h0C: esc = 2;
                    8'h09: esc = 3;
                    8'h0D: esc = 4;
                    default: ;
                endcase
            end
            2: begin
                esc = 0;
                if (c >= 2 && c <= 126)
                begin
                    pg = c; lw = c;
                    if (tp >= c) tp = 1;
                    if (ln > c) ln = 1;
                end
            end
            3: begin esc = 0; if (c >= 1 && c <= 132) pos = c; end
            4: begin
                esc = 0;
                if (c == 8'h50 && loc == 0)
                begin
                    pos = 1; lm = 1; rm = 132; ln = 1; tp = 1; lw = 66; pg = 66; nM++;
                end
            end
            default:
                if (c == 8'h1B) esc = 1;
                else if (c >= 8'h20 && c <= 8'h7E)
                begin
                    pc = c;
                    if (pos == 132) nD++;
                    else begin nS++; if (pos == rm) nA++; pos++; end
                end
                else if (c == 8'h0D) begin pos = lm; if (alf != 0) lf(); end
                else if (c == 8'h0A) lf();
                else if (c == 8'h08) begin if (pos > 1) pos--; end
                else if (c == 8'h0C) ln = tp;
        endcase
    endfunction : mdl

    task automatic close_out;
        fails += h.tmo;
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        h.xfer(w, a, d, q, e);
        if (h.tmo != 0)
            close_out();
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        `CK({e, q}, {xe, x})
    endtask : rd

    task automatic ch(input int c);
        logic [31:0] q;
        logic e;
        mdl(c);
        bus(1'b1, tmc_pkg::OFS_CHAR, {24'($urandom), 8'(c)}, q, e);
        repeat (2) @(posedge sys_clk);
        #1;
        `CK({carriagePos, paperLine, printChar}, {8'(pos), 7'(ln), 8'(pc)})
    endtask : ch

    task automatic es(input int c);
        ch(8'h1B);
        ch(c);
    endtask : es

    task automatic ctl(input int l, input int a);
        logic [31:0] q;
        logic e;
        loc = l;
        alf = a;
        bus(1'b1, tmc_pkg::OFS_CTRL, {30'h0, 1'(a), 1'(l)}, q, e);
        rd(tmc_pkg::OFS_CTRL, {30'h0, 1'(a), 1'(l)}, 1'b0);
    endtask : ctl

    task automatic endt(input string s);
        `CK({gS, gA, gD, gM}, {nS, nA, nD, nM})
        $display("test %s done", s);
    endtask : endt

    initial
    begin
        void'($urandom(26));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        rd(tmc_pkg::OFS_CTRL, 32'h1, 1'b0);
        rd(tmc_pkg::OFS_HMARG, 32'h8401, 1'b0);
        rd(tmc_pkg::OFS_VMARG, 32'h4201, 1'b0);
        rd(tmc_pkg::OFS_POS, 32'h420101, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        endt("reset");
        n = 5 + $urandom % 20;
        repeat (n) ch(8'h20 + $urandom % 95);
        es(8'h39);
        repeat (30) ch(8'h41);
        es(8'h30);
        ch(8'h08);
        repeat (3) ch(8'h42);
        ch(8'h0D);
        rd(tmc_pkg::OFS_HMARG, {16'h0, 8'(rm), 8'(lm)}, 1'b0);
        repeat (n + 2) ch(8'h08);
        es(8'h09);
        ch(n + 10);
        ch(8'h0D);
        es(8'h09);
        ch(1);
        repeat (140) ch(8'h43);
        endt("horizontal");
        repeat (2) ch(8'h0A);
        es(8'h54);
        repeat (3) ch(8'h0A);
        es(8'h4C);
        es(8'h54);
        rd(tmc_pkg::OFS_VMARG, 32'h0603, 1'b0);
        ch(8'h0A);
        ch(8'h0A);
        ch(8'h0C);
        ctl(1, 1);
        ch(8'h0D);
        es(8'h0C);
        ch(10);
        rd(tmc_pkg::OFS_VMARG, 32'h0A03, 1'b0);
        es(8'h43);
        rd(tmc_pkg::OFS_VMARG, 32'h0A01, 1'b0);
        es(8'h0D);
        ch(8'h50);
        endt("vertical");
        ctl(0, 0);
        ch(8'h44);
        es(8'h0D);
        ch(8'h50);
        rd(tmc_pkg::OFS_HMARG, 32'h8401, 1'b0);
        rd(tmc_pkg::OFS_VMARG, 32'h4201, 1'b0);
        endt("clear");
        close_out();
    end
endmodule : tb

`default_nettype wire
